// ===== design/usb_power_pkg.sv
/*
 * shared constants and types for the host-mode bus power control block:
 * register indices and byte addresses, field positions, reset values, carriers.
 * assumes a 32-bit apb slave port with 12-bit byte addresses.
 */
package usb_power_pkg;

   // register indices; byte address is four times the index
   localparam logic [11:0] BPC_IDX         = 12'h001;
   localparam logic [11:0] ROLE_IDX        = 12'h003;
   localparam logic [11:0] BPC_ADDR        = {BPC_IDX[9:0], 2'b00};
   localparam logic [11:0] ROLE_ADDR       = {ROLE_IDX[9:0], 2'b00};

   // bus_power_control field positions
   localparam int          BPC_PWRDN_BIT   = 0;
   localparam int          BPC_SUSPEND_BIT = 1;
   localparam int          BPC_RESUME_BIT  = 2;
   localparam int          BPC_RESET_BIT   = 3;
   localparam int          BPC_RSVD_LSB    = 4;
   localparam logic [1:0]  BPC_RSVD_VALUE  = 2'h2;
   localparam logic [7:0]  BPC_RESET_VALUE = 8'h20;

   // role_control_register field positions
   localparam int          ROLE_HOST_BIT   = 0;
   localparam int          ROLE_DM_BIT     = 1;
   localparam int          ROLE_DP_BIT     = 2;
   localparam logic [7:0]  ROLE_RESET_VALUE = 8'h00;

   localparam logic [31:0] APB_DATA_ZERO   = 32'h0000_0000;

   // what the control block asks of the line
   typedef struct packed {
      logic pwrdn;
      logic bus_reset;
      logic resume;
      logic suspend;
   } line_req_s;

   // registered drive of the two data lines
   typedef struct packed {
      logic dp_o;
      logic dp_oe;
      logic dm_o;
      logic dm_oe;
   } line_drive_s;

   localparam line_drive_s LINE_RELEASED = '{dp_o: 1'b0, dp_oe: 1'b0, dm_o: 1'b0, dm_oe: 1'b0};
   localparam line_drive_s LINE_SE0      = '{dp_o: 1'b0, dp_oe: 1'b1, dm_o: 1'b0, dm_oe: 1'b1};
   localparam line_drive_s LINE_K        = '{dp_o: 1'b0, dp_oe: 1'b1, dm_o: 1'b1, dm_oe: 1'b1};

endpackage

// ===== design/usb_line_driver.sv
/*
 * registered driver for the two usb data lines: turns the control request into
 * se0 (bus reset), k state (resume) or released lines.
 * assumes external pull resistors define the idle level while released.
 */
`timescale 1ns/1ps
module usb_line_driver
   import usb_power_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // request from the control register
   input  wire line_req_s   req,
   // line drive and transceiver power
   output line_drive_s      drive,
   output logic             phy_power_down
);

   line_drive_s drive_r;
   line_drive_s drive_nxt;
   logic        pwrdn_r;
   logic        pwrdn_nxt;

   always_comb
   begin
      pwrdn_nxt = req.pwrdn;
      // a powered-down transceiver cannot drive, so it wins over all signaling
      if (req.pwrdn)
      begin
         drive_nxt = LINE_RELEASED;
      end
      else if (req.bus_reset)
      begin
         drive_nxt = LINE_SE0;
      end
      else if (req.resume)
      begin
         drive_nxt = LINE_K;
      end
      else
      begin
         // suspended or idle: lines released, pulls hold the level
         drive_nxt = LINE_RELEASED;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         drive_r <= LINE_RELEASED;
         pwrdn_r <= 1'b0;
      end
      else
      begin
         drive_r <= drive_nxt;
         pwrdn_r <= pwrdn_nxt;
      end
   end

   assign drive          = drive_r;
   assign phy_power_down = pwrdn_r;

endmodule

// ===== design/usb_bus_power_control.sv
/*
 * host-mode bus power control register behind an apb slave, steering bus
 * reset, resume and suspend signaling and the transceiver power-down.
 * assumes line inputs synchronous to ref_clk and a single 25 mhz clock.
 */
// Notes on behaviour
// [RULE1] the power control register is eight bits wide and reads 0x20 after reset.
// [RULE2] bits 5:4 always read 0x2 and ignore writes; software keeps them on read-modify-write.
// [RULE3] in host mode bus reset is driven on the lines while the reset bit holds 1.
// [RULE4] in host mode writing 0 to the reset bit stops bus reset at once.
// [RULE5] in host mode setting the resume bit while suspended starts resume signaling.
// [RULE6] in host mode writing 0 to the resume bit ends resume signaling.
// [RULE7] software clears the resume bit 20 ms after setting it; hardware never times it.
// [RULE8] in host mode the suspend bit is write-one-to-set and a written 0 does nothing.
// [RULE9] the transceiver is powered down while its bit is 1 and a written 0 does nothing.
// [RULE10] the block leaves reset in device mode; host meanings apply only once host mode is selected.
// [RULE11] reserved at 5:4, reset at 3, resume at 2, suspend at 1, power-down at 0.
`timescale 1ns/1ps
module usb_bus_power_control
   import usb_power_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // usb data lines
   input  wire logic        usb_dp_i,
   input  wire logic        usb_dm_i,
   output logic             usb_dp_o,
   output logic             usb_dp_oe,
   output logic             usb_dm_o,
   output logic             usb_dm_oe,
   // transceiver and status
   output logic             phy_power_down,
   output logic             host_mode,
   output logic             bus_suspended
);

   // apb response state
   logic        pready_r;
   logic        pready_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;

   // control state
   logic        host_r;
   logic        host_nxt;
   logic        rst_sig_r;
   logic        rst_sig_nxt;
   logic        resume_r;
   logic        resume_nxt;
   logic        suspend_r;
   logic        suspend_nxt;
   logic        pwrdn_r;
   logic        pwrdn_nxt;
   logic [1:0]  line_r;
   logic [1:0]  line_nxt;

   logic        setup;
   logic        access;
   logic        wr_bpc;
   logic        wr_role;
   logic        lane0;
   logic [7:0]  bpc_view;
   logic [7:0]  role_view;
   line_req_s   req;
   line_drive_s drive;

   assign setup   = psel && !penable;
   // a write lands only at the edge that completes the access phase
   assign access  = psel && penable && pready_r;
   assign lane0   = pstrb[0];
   assign wr_bpc  = access && pwrite && lane0 && (paddr == BPC_ADDR);
   assign wr_role = access && pwrite && lane0 && (paddr == ROLE_ADDR);

   always_comb
   begin
      bpc_view                             = 8'h00;
      bpc_view[BPC_RSVD_LSB +: 2]          = BPC_RSVD_VALUE; // RULE2
      bpc_view[BPC_RESET_BIT]              = rst_sig_r; // RULE11
      bpc_view[BPC_RESUME_BIT]             = resume_r;
      bpc_view[BPC_SUSPEND_BIT]            = suspend_r;
      bpc_view[BPC_PWRDN_BIT]              = pwrdn_r;
      role_view                            = ROLE_RESET_VALUE;
      role_view[ROLE_HOST_BIT]             = host_r;
      role_view[ROLE_DM_BIT]               = line_r[0];
      role_view[ROLE_DP_BIT]               = line_r[1];
   end

   // apb answer: no wait state, ready is registered from the setup cycle, so every bus output comes from a flip-flop
   always_comb
   begin
      pready_nxt  = 1'b0;
      prdata_nxt  = prdata_r;
      pslverr_nxt = 1'b0;
      if (setup)
      begin
         pready_nxt = 1'b1;
         prdata_nxt = APB_DATA_ZERO;
         if (paddr == BPC_ADDR)
         begin
            prdata_nxt[7:0] = bpc_view; // RULE1
         end
         else if (paddr == ROLE_ADDR)
         begin
            prdata_nxt[7:0] = role_view;
         end
         else
         begin
            pslverr_nxt = 1'b1;
         end
      end
      else if (psel && penable && !pready_r)
      begin
         // master entered access without a fresh setup edge seen: answer at the next edge
         pready_nxt = 1'b1;
      end
   end

   always_comb
   begin
      host_nxt    = host_r;
      rst_sig_nxt = rst_sig_r;
      resume_nxt  = resume_r;
      suspend_nxt = suspend_r;
      pwrdn_nxt   = pwrdn_r;
      line_nxt    = {usb_dp_i, usb_dm_i};

      if (wr_role)
      begin
         host_nxt = pwdata[ROLE_HOST_BIT]; // RULE10
      end

      if (wr_bpc)
      begin
         // power-down only ever sets; a 0 leaves it alone until reset
         if (pwdata[BPC_PWRDN_BIT])
         begin
            pwrdn_nxt = 1'b1; // RULE9
         end
         if (host_r)
         begin
            rst_sig_nxt = pwdata[BPC_RESET_BIT]; // RULE3 RULE4
            if (!pwdata[BPC_RESUME_BIT])
            begin
               // end of resume wakes the bus, unless suspend is set again below
               if (resume_r)
               begin
                  suspend_nxt = 1'b0;
               end
               resume_nxt = 1'b0; // RULE6
            end
            else if (suspend_r)
            begin
               // no timer here: resume lasts until software writes 0
               resume_nxt = 1'b1; // RULE5 RULE7
            end
            if (pwdata[BPC_SUSPEND_BIT])
            begin
               suspend_nxt = 1'b1; // RULE8
            end
         end
      end

      // dropping host mode returns the reset, resume and suspend bits to their device-mode rest state
      if (wr_role && !pwdata[ROLE_HOST_BIT])
      begin
         rst_sig_nxt = 1'b0; // RULE10
         resume_nxt  = 1'b0;
         suspend_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= APB_DATA_ZERO;
         pslverr_r <= 1'b0;
         host_r    <= 1'b0; // RULE10
         rst_sig_r <= BPC_RESET_VALUE[BPC_RESET_BIT]; // RULE1
         resume_r  <= BPC_RESET_VALUE[BPC_RESUME_BIT];
         suspend_r <= BPC_RESET_VALUE[BPC_SUSPEND_BIT];
         pwrdn_r   <= BPC_RESET_VALUE[BPC_PWRDN_BIT];
         line_r    <= 2'h0;
      end
      else
      begin
         pready_r  <= pready_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         host_r    <= host_nxt;
         rst_sig_r <= rst_sig_nxt;
         resume_r  <= resume_nxt;
         suspend_r <= suspend_nxt;
         pwrdn_r   <= pwrdn_nxt;
         line_r    <= line_nxt;
      end
   end

   // signaling only reaches the lines while host mode is selected
   always_comb
   begin
      req.pwrdn     = pwrdn_r; // RULE9
      req.bus_reset = host_r && rst_sig_r; // RULE3
      req.resume    = host_r && resume_r; // RULE5
      req.suspend   = host_r && suspend_r;
   end

   usb_line_driver u_line_driver (
      .ref_clk        (ref_clk),
      .reset_n        (reset_n),
      .req            (req),
      .drive          (drive),
      .phy_power_down (phy_power_down)
   );

   assign pready        = pready_r;
   assign prdata        = prdata_r;
   assign pslverr       = pslverr_r;
   assign usb_dp_o      = drive.dp_o;
   assign usb_dp_oe     = drive.dp_oe;
   assign usb_dm_o      = drive.dm_o;
   assign usb_dm_oe     = drive.dm_oe;
   assign host_mode     = host_r;
   assign bus_suspended = suspend_r;

endmodule

// ===== verification/usb_peripheral_model.sv
/* attached full-speed peripheral seen from the host lines.
   assumes the host drives through output enables and holds pull-downs. */
`timescale 1ns/1ps
module usb_peripheral_model
(
   // host drive
   input  wire logic usb_dp_o,
   input  wire logic usb_dp_oe,
   input  wire logic usb_dm_o,
   input  wire logic usb_dm_oe,
   // line levels back to the host
   output logic      usb_dp_i,
   output logic      usb_dm_i
);
   // released lines settle at the pull levels: dp pulled up by the peripheral
   assign usb_dp_i = usb_dp_oe ? usb_dp_o : 1'b1;
   assign usb_dm_i = usb_dm_oe ? usb_dm_o : 1'b0;
endmodule

// ===== verification/usb_bus_power_control_checker.sv
/* assertions on the bus power control ports.
   assumes binding to usb_bus_power_control, single clock domain. */
`timescale 1ns/1ps
module usb_bus_power_control_checker
   import usb_power_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset_n,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // lines and status
   input wire logic        usb_dp_o,
   input wire logic        usb_dp_oe,
   input wire logic        usb_dm_o,
   input wire logic        usb_dm_oe,
   input wire logic        phy_power_down,
   input wire logic        host_mode,
   input wire logic        bus_suspended
);
   logic acc;
   logic wr;
   logic rel;
   assign acc = psel && penable && pready;
   // power-down overrides line drive, so line checks exclude it
   assign wr  = acc && pwrite && paddr == BPC_ADDR && pstrb[0] && host_mode && !phy_power_down && !pwdata[0];
   assign rel = !usb_dp_oe && !usb_dm_oe;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_ready_answer: assert property (psel && !penable |=> pready) else $error("no ready");
   a_unmapped_error: assert property (acc && paddr != BPC_ADDR && paddr != ROLE_ADDR |-> pslverr)
      else $error("no slave error");
   a_read_fixed: assert property (acc && !pwrite && paddr == BPC_ADDR |-> prdata[31:6] == 26'h000_0000
      && prdata[5:4] == BPC_RSVD_VALUE) else $error("bad fixed bits");
   a_reset_drive: assert property (wr && pwdata[3] |-> ##2 usb_dp_oe && usb_dm_oe && !usb_dp_o && !usb_dm_o)
      else $error("no se0");
   a_signal_end: assert property (wr && !pwdata[3] && !pwdata[2] |-> ##2 rel) else $error("lines held");
   a_resume_k: assert property (wr && bus_suspended && pwdata[2] && !pwdata[3]
      |-> ##2 usb_dp_oe && usb_dm_oe && !usb_dp_o && usb_dm_o) else $error("no k state");
   a_suspend_set: assert property (wr && pwdata[1] |-> ##[1:2] bus_suspended) else $error("no suspend");
   a_suspend_kept: assert property (wr && bus_suspended && pwdata[2] |=> bus_suspended [*2])
      else $error("suspend lost");
   a_pwrdn_sticky: assert property (!$fell(phy_power_down)) else $error("power-down cleared");
   a_pwrdn_quiet: assert property (phy_power_down |-> rel) else $error("drive while down");
   a_device_quiet: assert property (!host_mode && !$past(host_mode) && !$past(host_mode, 2) |-> rel)
      else $error("drive in device mode");
endmodule

bind usb_bus_power_control usb_bus_power_control_checker i_checker (.*);

// ===== verification/tb_usb_bus_power_control.sv
/* self-checking bench: apb master, queue of expected answers, line model.
   assumes the checker is bound to the design by its own file. */
`timescale 1ns/1ps
module tb_usb_bus_power_control;
   import usb_power_pkg::*;
   // stand-in for the 20 ms software wait, shortened to keep the run brief
   localparam int RESUME_CYCLES = 200;
   logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic        usb_dp_i, usb_dm_i, usb_dp_o, usb_dp_oe, usb_dm_o, usb_dm_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [32:0] expq[$];
   logic [32:0] exp_v;
   logic [15:0] seed;
   int          failures, compares;

   usb_bus_power_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .usb_dp_i(usb_dp_i), .usb_dm_i(usb_dm_i), .usb_dp_o(usb_dp_o),
      .usb_dp_oe(usb_dp_oe), .usb_dm_o(usb_dm_o), .usb_dm_oe(usb_dm_oe), .phy_power_down(),
      .host_mode(), .bus_suspended());
   usb_peripheral_model i_peer (.usb_dp_o(usb_dp_o), .usb_dp_oe(usb_dp_oe), .usb_dm_o(usb_dm_o),
      .usb_dm_oe(usb_dm_oe), .usb_dp_i(usb_dp_i), .usb_dm_i(usb_dm_i));

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // no release here: the next setup follows at once, idle() ends a burst
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] e, input logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      expq.push_back({err, w ? 32'h0000_0000 : e});
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'h1, 32'h0000_0000, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000, 4'h1, e, 1'b0);
   endtask

   task automatic idle();
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   always @(posedge ref_clk)
      if (psel && penable && pready === 1'b1)
      begin
         exp_v = expq.pop_front();
         chk({pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_v);
      end

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      report_and_stop();
   end

   initial
   begin
      {reset_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      seed = 16'h99ed;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(ROLE_ADDR, 32'h0000_0004);
      rd(BPC_ADDR, 32'h0000_0020);
      wr(BPC_ADDR, 32'h0000_000e);
      rd(BPC_ADDR, 32'h0000_0020);
      wr(ROLE_ADDR, 32'h0000_0001);
      rd(ROLE_ADDR, 32'h0000_0005);
      wr(BPC_ADDR, 32'h0000_0018);
      rd(BPC_ADDR, 32'h0000_0028);
      // the line levels loop back through the peripheral model into the role register
      rd(ROLE_ADDR, 32'h0000_0001);
      wr(BPC_ADDR, 32'h0000_0030);
      rd(BPC_ADDR, 32'h0000_0020);
      rd(ROLE_ADDR, 32'h0000_0005);
      wr(BPC_ADDR, 32'h0000_0002);
      wr(BPC_ADDR, 32'h0000_0020);
      rd(BPC_ADDR, 32'h0000_0022);
      wr(BPC_ADDR, 32'h0000_0026);
      rd(BPC_ADDR, 32'h0000_0026);
      rd(ROLE_ADDR, 32'h0000_0003);
      idle();
      repeat (RESUME_CYCLES) @(posedge ref_clk);
      wr(BPC_ADDR, 32'h0000_0000);
      rd(BPC_ADDR, 32'h0000_0020);
      rd(ROLE_ADDR, 32'h0000_0005);
      repeat (4)
      begin
         seed = lfsr(seed);
         xfer(seed[0], {1'b1, seed[9:1], 2'b00}, {seed, seed}, 4'hf, 32'h0000_0000, 1'b1);
      end
      xfer(1'b1, BPC_ADDR, 32'h0000_0001, 4'h0, 32'h0000_0000, 1'b0);
      rd(BPC_ADDR, 32'h0000_0020);
      wr(BPC_ADDR, 32'h0000_0001);
      wr(BPC_ADDR, 32'h0000_0000);
      rd(BPC_ADDR, 32'h0000_0021);
      idle();
      repeat (3) @(posedge ref_clk);
      report_and_stop();
   end
endmodule
